// ==== rtl/ildiag_pkg.sv ====
package ildiag_pkg;

  // Clock and base tick
  localparam int          CLK_HZ        = 50_000_000;
  localparam int          TICK_NS       = 1_000_000;
  localparam int          TICK_CYCLES   = int'((64'(CLK_HZ) * TICK_NS) / 64'd1_000_000_000);
  localparam int          TICK_W        = 16;
  localparam int          MS_W          = 21;

  // Times counted in 1 ms ticks
  localparam int          BLINK_HALF_MS = 500;
  localparam int          GRACE_MIN     = 30;
  localparam int          GRACE_MS      = GRACE_MIN * 60_000;
  localparam int          INHIBIT_MIN   = 10;
  localparam int          INHIBIT_MS    = INHIBIT_MIN * 60_000;
  localparam int          FLASH_ON_MS   = 200;
  localparam int          FLASH_GAP_MS  = 300;
  localparam int          FLASH_PAUSE_MS = 1500;

  // Register map
  localparam int          ADDR_W        = 8;
  localparam logic [7:0]  CTRL_OFFSET   = 8'h00;
  localparam logic [7:0]  STATUS_OFFSET = 8'h04;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
  localparam int          CTRL_DOOR_ONLY_BIT = 0;
  localparam int          CTRL_RETEACH_BIT   = 1;
  localparam int          CTRL_LOCK_POL_BIT  = 2;
  localparam int          CTRL_W             = 3;
  localparam int          STAT_STATE_LSB     = 0;
  localparam int          STAT_CODE_LSB      = 4;
  localparam int          STAT_SAFE_BIT      = 8;
  localparam int          STAT_DIAG_BIT      = 9;
  localparam int          STAT_INHIBIT_BIT   = 10;
  localparam int          STAT_MAGNET_BIT    = 11;
  localparam int          STAT_INOK_BIT      = 12;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // Fault codes, value is the red pulse count except CODE_INTERNAL, which shows steady red
  localparam logic [2:0]  CODE_NONE     = 3'h0;
  localparam logic [2:0]  CODE_OUT_A    = 3'h1;
  localparam logic [2:0]  CODE_OUT_B    = 3'h2;
  localparam logic [2:0]  CODE_CROSS    = 3'h3;
  localparam logic [2:0]  CODE_TEMP     = 3'h4;
  localparam logic [2:0]  CODE_ACTUATOR = 3'h5;
  localparam logic [2:0]  CODE_HANDLE   = 3'h6;
  localparam logic [2:0]  CODE_INTERNAL = 3'h7;

  // Synchronised pin positions
  localparam int          PIN_UPS_A     = 0;
  localparam int          PIN_UPS_B     = 1;
  localparam int          PIN_CLOSED    = 2;
  localparam int          PIN_LOCKED    = 3;
  localparam int          PIN_LOCKPOSS  = 4;
  localparam int          PIN_LOCKCTRL  = 5;
  localparam int          PIN_FLT_A     = 6;
  localparam int          PIN_FLT_B     = 7;
  localparam int          PIN_CROSS     = 8;
  localparam int          PIN_TEMP      = 9;
  localparam int          PIN_ACTUATOR  = 10;
  localparam int          PIN_HANDLE    = 11;
  localparam int          PIN_INTERNAL  = 12;
  localparam int          PIN_TEACH     = 13;
  localparam int          PIN_LEARNED   = 14;
  localparam int          PIN_N         = 15;

  typedef enum logic [1:0] {
    ST_NORMAL = 2'b00,
    ST_WARN   = 2'b01,
    ST_FAULT  = 2'b10,
    ST_ERROR  = 2'b11
  } ildiag_state_type;

  typedef enum logic [1:0] {
    PH_IDLE  = 2'b00,
    PH_ON    = 2'b01,
    PH_GAP   = 2'b10,
    PH_PAUSE = 2'b11
  } ildiag_phase_type;

endpackage : ildiag_pkg

// ==== rtl/ildiag_flash.sv ====
`timescale 1ns/1ps
module ildiag_flash
  import ildiag_pkg::*;
(
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Millisecond tick and code to show
  input  wire logic       tick,
  input  wire logic [2:0] code,
  // Red lamp pulse train
  output logic            flash_q
);
  import ildiag_pkg::*;

  ildiag_phase_type  phase_q, phase_d;
  logic [MS_W-1:0]   cnt_q, cnt_d;
  logic [2:0]        idx_q, idx_d;
  logic [2:0]        lat_q, lat_d;

  // Code is latched per group so a change never cuts a group short
  always_comb begin
    phase_d = phase_q;
    cnt_d   = cnt_q;
    idx_d   = idx_q;
    lat_d   = lat_q;
    if (tick && phase_q != PH_IDLE) begin
      cnt_d = cnt_q + 1'b1;
    end
    unique case (phase_q)
      PH_IDLE: begin
        if (code != CODE_NONE && code != CODE_INTERNAL) begin
          phase_d = PH_ON;
          lat_d   = code;
          idx_d   = 3'h1;
          cnt_d   = '0;
        end
      end
      PH_ON: begin
        if (tick && cnt_q == MS_W'(FLASH_ON_MS - 1)) begin
          cnt_d   = '0;
          phase_d = (idx_q == lat_q) ? PH_PAUSE : PH_GAP;
        end
      end
      PH_GAP: begin
        if (tick && cnt_q == MS_W'(FLASH_GAP_MS - 1)) begin
          cnt_d   = '0;
          idx_d   = idx_q + 1'b1;
          phase_d = PH_ON;
        end
      end
      PH_PAUSE: begin
        // Long dark pause lets the observer count the group
        if (tick && cnt_q == MS_W'(FLASH_PAUSE_MS - 1)) begin
          cnt_d   = '0;
          phase_d = PH_IDLE;
        end
      end
    endcase
  end

  // Pulse train registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_q <= PH_IDLE;
      cnt_q   <= '0;
      idx_q   <= 3'h0;
      lat_q   <= CODE_NONE;
      flash_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
      cnt_q   <= cnt_d;
      idx_q   <= idx_d;
      lat_q   <= lat_d;
      flash_q <= (phase_d == PH_ON);
    end
  end

  a_pause_count: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(phase_q == PH_PAUSE) |-> (idx_q == lat_q) && (lat_q != CODE_NONE))
    else $error("pause began before the pulse count was reached");

  a_pause_dark: assert property (@(posedge aclk) disable iff (!aresetn)
    (phase_q == PH_PAUSE) |-> !flash_q)
    else $error("red lamp lit during the group pause");

endmodule : ildiag_flash

// ==== rtl/ildiag_top.sv ====
`timescale 1ns/1ps
module ildiag_top
  import ildiag_pkg::*;
#(
  parameter int TICK_CYC      = TICK_CYCLES,
  parameter int GRACE_TICKS   = GRACE_MS,
  parameter int INHIBIT_TICKS = INHIBIT_MS
) (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write channels
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read channels
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Upstream chain, guard sensing and lock request
  input  wire logic              upstream_safety_input_a,
  input  wire logic              upstream_safety_input_b,
  input  wire logic              guard_closed,
  input  wire logic              guard_locked,
  input  wire logic              locking_possible,
  input  wire logic              lock_control,
  // Fault sensing
  input  wire logic              out_a_fault,
  input  wire logic              out_b_fault,
  input  wire logic              cross_short,
  input  wire logic              over_temperature,
  input  wire logic              actuator_fault,
  input  wire logic              handle_fault,
  input  wire logic              internal_error,
  // Actuator teach-in
  input  wire logic              teach_active,
  input  wire logic              new_actuator_learned,
  // Lamps, outputs and solenoid
  output logic                   green_lamp_q,
  output logic                   yellow_lamp_q,
  output logic                   red_lamp_q,
  output logic                   diag_out_q,
  output logic                   safety_output_a_q,
  output logic                   safety_output_b_q,
  output logic                   magnet_on_q
);
  import ildiag_pkg::*;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Register index decode, shared by both channels
  function automatic logic [1:0] reg_index(input logic [ADDR_W-1:0] a);
    if (a == CTRL_OFFSET) begin
      reg_index = 2'h1;
    end else if (a == STATUS_OFFSET) begin
      reg_index = 2'h2;
    end else begin
      reg_index = 2'h0;
    end
  endfunction : reg_index

  // Two-flop synchronisers for every pin
  logic [PIN_N-1:0] pin_raw, pin_m_q, pin_s;
  assign pin_raw = {new_actuator_learned, teach_active, internal_error, handle_fault,
                    actuator_fault, over_temperature, cross_short, out_b_fault, out_a_fault,
                    lock_control, locking_possible, guard_locked, guard_closed,
                    upstream_safety_input_b, upstream_safety_input_a};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_m_q <= '0;
      pin_s   <= '0;
    end else begin
      pin_m_q <= pin_raw;
      pin_s   <= pin_m_q;
    end
  end

  logic in_ok, closed, locked, teach;
  assign in_ok  = pin_s[PIN_UPS_A] & pin_s[PIN_UPS_B];
  assign closed = pin_s[PIN_CLOSED];
  assign locked = pin_s[PIN_LOCKED] & closed;
  assign teach  = pin_s[PIN_TEACH];

  // Millisecond tick and 1 Hz blink
  logic [TICK_W-1:0] tick_cnt_q, tick_cnt_d;
  logic [MS_W-1:0]   blink_cnt_q, blink_cnt_d;
  logic              tick_q, tick_d, blink_q, blink_d;
  always_comb begin
    tick_d      = (tick_cnt_q == TICK_W'(TICK_CYC - 1));
    tick_cnt_d  = tick_d ? '0 : tick_cnt_q + 1'b1;
    blink_cnt_d = blink_cnt_q;
    blink_d     = blink_q;
    if (tick_q) begin
      blink_cnt_d = blink_cnt_q + 1'b1;
      if (blink_cnt_q == MS_W'(BLINK_HALF_MS - 1)) begin
        blink_cnt_d = '0;
        blink_d     = !blink_q;
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt_q  <= '0;
      tick_q      <= 1'b0;
      blink_cnt_q <= '0;
      blink_q     <= 1'b0;
    end else begin
      tick_cnt_q  <= tick_cnt_d;
      tick_q      <= tick_d;
      blink_cnt_q <= blink_cnt_d;
      blink_q     <= blink_d;
    end
  end

  // Fault classification, highest priority first
  logic [2:0] imm_code, warn_code;
  always_comb begin
    if (pin_s[PIN_INTERNAL]) begin
      imm_code = CODE_INTERNAL;
    end else if (pin_s[PIN_HANDLE]) begin
      imm_code = CODE_HANDLE;
    end else if (pin_s[PIN_ACTUATOR]) begin
      imm_code = CODE_ACTUATOR;
    end else begin
      imm_code = CODE_NONE;
    end
    if (pin_s[PIN_CROSS] || (pin_s[PIN_FLT_A] && pin_s[PIN_FLT_B])) begin
      warn_code = CODE_CROSS;
    end else if (pin_s[PIN_FLT_A]) begin
      warn_code = CODE_OUT_A;
    end else if (pin_s[PIN_FLT_B]) begin
      warn_code = CODE_OUT_B;
    end else if (pin_s[PIN_TEMP]) begin
      warn_code = CODE_TEMP;
    end else begin
      warn_code = CODE_NONE;
    end
  end

  // Error and warning state machine
  ildiag_state_type state_q, state_d;
  logic [2:0]       code_q, code_d;
  logic [MS_W-1:0]  grace_q, grace_d;
  logic             opened_q, opened_d, clear_ok;
  assign clear_ok = opened_q && closed && imm_code == CODE_NONE
                    && !(state_q == ST_FAULT && warn_code != CODE_NONE);
  always_comb begin
    state_d  = state_q;
    code_d   = code_q;
    grace_d  = grace_q;
    opened_d = opened_q || !closed;
    // A new shutdown cause always wins over any clear in the same cycle
    if (imm_code != CODE_NONE) begin
      state_d  = ST_ERROR;
      code_d   = (state_q == ST_ERROR) ? code_q : imm_code;
      opened_d = 1'b0;
    end else begin
      unique case (state_q)
        ST_NORMAL: begin
          if (warn_code != CODE_NONE) begin
            state_d = ST_WARN;
            code_d  = warn_code;
            grace_d = '0;
          end
        end
        ST_WARN: begin
          code_d = warn_code;
          if (warn_code == CODE_NONE) begin
            state_d = ST_NORMAL;
          end else if (tick_q) begin
            grace_d = grace_q + 1'b1;
            if (grace_q == MS_W'(GRACE_TICKS - 1)) begin
              state_d  = ST_FAULT;
              opened_d = 1'b0;
            end
          end
        end
        ST_FAULT, ST_ERROR: begin
          if (clear_ok) begin
            state_d = ST_NORMAL;
            code_d  = CODE_NONE;
          end
        end
      endcase
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q  <= ST_NORMAL;
      code_q   <= CODE_NONE;
      grace_q  <= '0;
      opened_q <= 1'b0;
    end else begin
      state_q  <= state_d;
      code_q   <= code_d;
      grace_q  <= grace_d;
      opened_q <= opened_d;
    end
  end

  // Enabling hold-off after a new actuator; reset clears it even if still pending
  logic [CTRL_W-1:0] ctrl_q, ctrl_d;
  logic [MS_W-1:0]   inh_cnt_q, inh_cnt_d;
  logic              inhibit_q, inhibit_d, learned_q;
  always_comb begin
    inh_cnt_d = inh_cnt_q;
    inhibit_d = inhibit_q;
    if (pin_s[PIN_LEARNED] && !learned_q && ctrl_q[CTRL_RETEACH_BIT]) begin
      inhibit_d = 1'b1;
      inh_cnt_d = '0;
    end else if (inhibit_q && tick_q) begin
      inh_cnt_d = inh_cnt_q + 1'b1;
      if (inh_cnt_q == MS_W'(INHIBIT_TICKS - 1)) begin
        inhibit_d = 1'b0;
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      inh_cnt_q <= '0;
      inhibit_q <= 1'b0;
      learned_q <= 1'b0;
    end else begin
      inh_cnt_q <= inh_cnt_d;
      inhibit_q <= inhibit_d;
      learned_q <= pin_s[PIN_LEARNED];
    end
  end

  // Red pulse generator
  logic flash;
  ildiag_flash u_flash (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (tick_q),
    .code    (code_q),
    .flash_q (flash)
  );

  // Lamps and outputs, all registered
  logic guard_ok, run_ok, safe_d, diag_d, green_d, yellow_d, red_d, magnet_d;
  always_comb begin
    guard_ok = ctrl_q[CTRL_DOOR_ONLY_BIT] ? closed : locked;
    run_ok   = (state_q == ST_NORMAL) || (state_q == ST_WARN);
    safe_d   = in_ok && guard_ok && run_ok && !teach && !inhibit_q;
    diag_d   = (locked || (closed && pin_s[PIN_LOCKPOSS])) && state_q == ST_NORMAL
               && !teach;
    green_d  = teach ? 1'b0 : ((!in_ok || inhibit_q) ? blink_q : 1'b1);
    if (teach) begin
      yellow_d = blink_q;
    end else if (state_q == ST_FAULT || state_q == ST_ERROR || !closed) begin
      yellow_d = 1'b0;
    end else begin
      yellow_d = locked ? 1'b1 : blink_q;
    end
    if (teach) begin
      red_d = 1'b1;
    end else if (state_q == ST_NORMAL) begin
      red_d = 1'b0;
    end else begin
      red_d = (code_q == CODE_INTERNAL) ? 1'b1 : flash;
    end
    // Lock request polarity depends on the solenoid variant
    magnet_d = ctrl_q[CTRL_LOCK_POL_BIT] ? pin_s[PIN_LOCKCTRL] : !pin_s[PIN_LOCKCTRL];
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      safety_output_a_q <= 1'b0;
      safety_output_b_q <= 1'b0;
      diag_out_q        <= 1'b0;
      green_lamp_q      <= 1'b0;
      yellow_lamp_q     <= 1'b0;
      red_lamp_q        <= 1'b0;
      magnet_on_q       <= 1'b0;
    end else begin
      safety_output_a_q <= safe_d;
      safety_output_b_q <= safe_d;
      diag_out_q        <= diag_d;
      green_lamp_q      <= green_d;
      yellow_lamp_q     <= yellow_d;
      red_lamp_q        <= red_d;
      magnet_on_q       <= magnet_d;
    end
  end

  // AXI4-Lite slave; address and data may arrive in either order
  logic              aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
  logic [ADDR_W-1:0] awaddr_q, awaddr_d;
  logic [31:0]       wdata_q, wdata_d, rdata_d, status;
  logic [3:0]        wstrb_q, wstrb_d;
  logic              bvalid_d, rvalid_d;
  logic [1:0]        bresp_d, rresp_d;
  assign status = {19'h0, in_ok, magnet_on_q, inhibit_q, diag_out_q, safety_output_a_q,
                   1'b0, code_q, 2'h0, state_q};
  always_comb begin
    aw_hold_d = aw_hold_q;
    awaddr_d  = awaddr_q;
    w_hold_d  = w_hold_q;
    wdata_d   = wdata_q;
    wstrb_d   = wstrb_q;
    ctrl_d    = ctrl_q;
    bvalid_d  = s_axi_bvalid && !s_axi_bready;
    bresp_d   = s_axi_bresp;
    rvalid_d  = s_axi_rvalid && !s_axi_rready;
    rresp_d   = s_axi_rresp;
    rdata_d   = s_axi_rdata;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_d = 1'b1;
      awaddr_d  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_hold_d = 1'b1;
      wdata_d  = s_axi_wdata;
      wstrb_d  = s_axi_wstrb;
    end
    if (aw_hold_q && w_hold_q && !s_axi_bvalid) begin
      aw_hold_d = 1'b0;
      w_hold_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = (reg_index(awaddr_q) == 2'h0) ? RESP_SLVERR : RESP_OKAY;
      if (reg_index(awaddr_q) == 2'h1 && wstrb_q[0]) begin
        ctrl_d = wdata_q[CTRL_W-1:0];
      end
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      unique case (reg_index(s_axi_araddr))
        2'h1: begin
          rdata_d = {29'h0, ctrl_q};
          rresp_d = RESP_OKAY;
        end
        2'h2: begin
          rdata_d = status;
          rresp_d = RESP_OKAY;
        end
        default: begin
          rdata_d = 32'h0;
          rresp_d = RESP_SLVERR;
        end
      endcase
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q     <= 1'b0;
      w_hold_q      <= 1'b0;
      awaddr_q      <= '0;
      wdata_q       <= 32'h0;
      wstrb_q       <= 4'h0;
      ctrl_q        <= CTRL_RESET[CTRL_W-1:0];
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= RESP_OKAY;
      s_axi_rdata   <= 32'h0;
    end else begin
      aw_hold_q     <= aw_hold_d;
      w_hold_q      <= w_hold_d;
      awaddr_q      <= awaddr_d;
      wdata_q       <= wdata_d;
      wstrb_q       <= wstrb_d;
      ctrl_q        <= ctrl_d;
      s_axi_awready <= !aw_hold_d && !bvalid_d;
      s_axi_wready  <= !w_hold_d && !bvalid_d;
      s_axi_bvalid  <= bvalid_d;
      s_axi_bresp   <= bresp_d;
      s_axi_arready <= !rvalid_d;
      s_axi_rvalid  <= rvalid_d;
      s_axi_rresp   <= rresp_d;
      s_axi_rdata   <= rdata_d;
    end
  end

  a_no_input_off: assert property (!in_ok |=> !safety_output_a_q && !safety_output_b_q)
    else $error("safety outputs on without upstream input");
  a_internal_red: assert property (
    (state_q == ST_ERROR && code_q == CODE_INTERNAL && !teach)
    |=> red_lamp_q && !safety_output_a_q)
    else $error("internal error without steady red and shutdown");
  a_error_latched: assert property (
    (state_q == ST_ERROR && !clear_ok) |=> state_q == ST_ERROR)
    else $error("error left without guard cycle");
  a_warn_diag_low: assert property ((state_q == ST_WARN) |=> !diag_out_q)
    else $error("diagnostic high during warning");
  a_warn_self_clear: assert property (
    (state_q == ST_WARN && warn_code == CODE_NONE && imm_code == CODE_NONE)
    |=> state_q == ST_NORMAL)
    else $error("warning did not clear with its cause");
  a_grace_expiry: assert property (
    (state_q == ST_WARN && tick_q && imm_code == CODE_NONE && warn_code != CODE_NONE
     && grace_q == MS_W'(GRACE_TICKS - 1))
    |=> state_q == ST_FAULT ##1 !safety_output_a_q)
    else $error("grace expiry did not shut down");
  a_immediate_stop: assert property (
    (imm_code != CODE_NONE) |=> state_q == ST_ERROR ##1 !safety_output_b_q)
    else $error("immediate fault did not shut down");
  a_yellow_locked: assert property (
    (locked && !teach && state_q == ST_NORMAL) |=> yellow_lamp_q)
    else $error("yellow not steady while locked");
  a_teach_lamps: assert property (teach |=> !green_lamp_q && red_lamp_q)
    else $error("teach-in lamp pattern wrong");
  a_door_only_on: assert property (
    (ctrl_q[CTRL_DOOR_ONLY_BIT] && closed && in_ok && !teach && !inhibit_q
     && state_q == ST_NORMAL) |=> safety_output_a_q)
    else $error("door-only variant dropped outputs while closed");

endmodule : ildiag_top

// ==== tb/ildiag_plc.sv ====
`timescale 1ns/1ps
// Controller side: turns a lock request into the lock pin level
module ildiag_plc (
  // Request and wiring variant
  input  wire logic lock_req,
  input  wire logic pol,
  // Pin to the interlock
  output logic      lock_control
);
  // Power-to-lock wants the pin high to lock, power-to-unlock low
  assign lock_control = pol ? lock_req : ~lock_req;
endmodule : ildiag_plc

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  import ildiag_pkg::*;
  logic        aclk, aresetn, awv, wv, bre, arv, rre, awrdy, wrdy, bvld, arrdy, rvld;
  logic        red, diag, safe, mag, lc, pol, grn, yel, sfb;
  logic [7:0]  ara, awa;
  logic [31:0] wd, rdat, d;
  logic [1:0]  brsp, rrsp, r;
  logic [14:0] p;
  int          n_fail, compares, x, m, c;
  ildiag_plc i_ildiag_plc (.lock_req(p[14]), .pol(pol), .lock_control(lc));
  // Short tick and grace so a run stays brief
  ildiag_top #(.TICK_CYC(5), .GRACE_TICKS(20), .INHIBIT_TICKS(10)) i_ildiag_top (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awrdy), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wrdy), .s_axi_bresp(brsp), .s_axi_bvalid(bvld), .s_axi_bready(bre),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arrdy), .s_axi_rdata(rdat),
    .s_axi_rresp(rrsp), .s_axi_rvalid(rvld), .s_axi_rready(rre),
    .upstream_safety_input_a(p[0]), .upstream_safety_input_b(p[1]), .guard_closed(p[2]),
    .guard_locked(p[3]), .locking_possible(p[4]), .lock_control(lc), .out_a_fault(p[5]),
    .out_b_fault(p[6]), .cross_short(p[7]), .over_temperature(p[8]),
    .actuator_fault(p[9]), .handle_fault(p[10]), .internal_error(p[11]),
    .teach_active(p[12]), .new_actuator_learned(p[13]), .green_lamp_q(grn),
    .yellow_lamp_q(yel), .red_lamp_q(red), .diag_out_q(diag), .safety_output_a_q(safe),
    .safety_output_b_q(sfb),
    .magnet_on_q(mag));
  // Clock, 20 ns
  initial begin
    aclk = 0;
    forever #10 aclk = ~aclk;
  end
  function automatic int xs();
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction : xs
  // Model: immediate causes beat warnings, bit n-1 of f is code n
  function automatic int mdl(input int f);
    return f[6] ? 7 : f[5] ? 6 : f[4] ? 5 : (f[2] | (f[0] & f[1])) ? 3 :
           f[0] ? 1 : f[1] ? 2 : f[3] ? 4 : 0;
  endfunction : mdl
  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
  endtask : wt
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  // Write one word; each channel released once taken, only the watchdog ends a hang
  task automatic wrt(input logic [7:0] a, input logic [31:0] v);
    awa <= a;
    wd <= v;
    awv <= 1;
    wv <= 1;
    bre <= 1;
    do begin
      @(posedge aclk);
      if (awrdy) awv <= 0;
      if (wrdy) wv <= 0;
    end while (!bvld);
    r = brsp;
    bre <= 0;
    @(posedge aclk);
  endtask : wrt
  // Read one word; rready stays up until the answer is seen
  task automatic rd(input logic [7:0] a);
    ara <= a;
    arv <= 1;
    rre <= 1;
    do begin
      @(posedge aclk);
      if (arrdy) arv <= 0;
    end while (!rvld);
    d = rdat;
    r = rrsp;
    rre <= 0;
    @(posedge aclk);
  endtask : rd
  // Settle, then compare status word and pins with the model
  task automatic st(input int cd, input int s);
    wt(10);
    rd(8'h04);
    chk(d & 32'h37f, (32'(s == 0) << 9) | (32'(s < 2) << 8) | (32'(cd) << 4) | 32'(s));
    chk(safe, s < 2);
    chk(sfb, s < 2);
    chk(diag, s == 0);
    chk(yel, s < 2);
    chk(grn, 1);
  endtask : st
  task automatic gcyc();
    p[2] <= 0;
    wt(8);
    p[2] <= 1;
  endtask : gcyc
  task automatic summarize();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize
  // Hang guard, far beyond the several hundred cycles needed
  initial begin
    wt(20000);
    n_fail++;
    summarize();
  end
  initial begin
    {aresetn, awv, wv, bre, arv, rre, pol, ara, awa, wd, p} = '0;
    n_fail = 0;
    compares = 0;
    x = 28689;
    wt(16);
    aresetn <= 1;
    p <= 15'h401f;
    rd(8'h00);
    chk(d, CTRL_RESET);
    rd(8'h40);
    chk(r, RESP_SLVERR);
    // Magnet follows the lock request in both wiring variants
    for (int k = 0; k < 4; k++) begin
      pol <= k[0];
      p[14] <= k[1];
      wrt(8'h00, 32'(k[0]) << CTRL_LOCK_POL_BIT);
      wt(8);
      chk(mag, k[1]);
    end
    // Unmapped write is refused and leaves the control word alone
    wrt(8'h40, 32'h7);
    chk(r, RESP_SLVERR);
    rd(8'h00);
    chk(d, 32'h1 << CTRL_LOCK_POL_BIT);
    $display("bus done");
    st(0, 0);
    // Each code alone; immediate ones with random warnings beside
    for (c = 1; c < 8; c++) begin
      m = (1 << (c - 1)) | (c > 4 ? xs() & 15 : 0);
      p[11:5] <= 7'(m);
      st(mdl(m), c > 4 ? 3 : 1);
      if (c == 7) chk(red, 1);
      p[11:5] <= 7'h0;
      if (c > 4) st(c, 3);
      if (c > 4) gcyc();
      st(0, 0);
      $display("code %0d done", c);
    end
    p[8] <= 1;
    wt(150);
    st(4, 2);
    p[8] <= 0;
    gcyc();
    st(0, 0);
    p[0] <= 0;
    wt(8);
    chk(safe, 0);
    chk(red, 0);
    $display("upstream done");
    // Teach-in lamp pattern: green off, red on, outputs off
    p[0] <= 1;
    p[12] <= 1;
    wt(8);
    chk({grn, red, safe}, 32'h2);
    // Closed but unlocked enables only in the door-only variant
    p[12] <= 0;
    p[3] <= 0;
    wt(8);
    chk(safe, 0);
    wrt(8'h00, 32'h1 << CTRL_DOOR_ONLY_BIT);
    wt(8);
    chk(safe, 1);
    // A newly learned actuator holds enabling off for the hold-off time
    wrt(8'h00, 32'h3);
    p[13] <= 1;
    wt(8);
    chk(safe, 0);
    wt(60);
    chk(safe, 1);
    $display("variants done");
    summarize();
  end
endmodule : testbench
